//--- common/simd_core_pkg.sv
// Package with the constants, types and encodings of the SIMD datapath core.
package simd_core_pkg;

  localparam int WORD_W      = 32;
  localparam int EXT_W       = 40;
  localparam int INSN_W      = 48;
  localparam int REG_COUNT   = 32;
  localparam int BANK_SIZE   = 16;
  localparam int REG_IDX_W   = 4;
  localparam int CBUF_SETS   = 16;
  localparam int CBUF_IDX_W  = 4;
  localparam int ADDR_W      = 17;
  localparam int CACHE_DEPTH = 32;
  localparam int CACHE_IDX_W = 5;
  localparam int PE_COUNT    = 2;

  // Memory size limits per access width, in words.
  localparam int MEM_WORDS_32 = 96 * 1024;
  localparam int MEM_WORDS_16 = 192 * 1024;
  localparam int MEM_WORDS_48 = 64 * 1024;

  // Floating-point field layout.
  localparam int F32_EXP_W  = 8;
  localparam int F32_MAN_W  = 23;
  localparam int F16_EXP_W  = 5;
  localparam int F16_MAN_W  = 10;
  localparam logic [7:0] F32_BIAS = 8'h7F;
  localparam logic [7:0] F16_BIAS = 8'h0F;
  localparam logic [7:0] F16_EXP_MAX = 8'h1F;

  // Mode bit position of the second element enable.
  localparam int SECOND_ELEMENT_ENABLE_BIT = 0;
  localparam int MODE_W = 8;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD,
    OP_SUB,
    OP_MUL,
    OP_MULADD,
    OP_ADDSUB,
    OP_SHL,
    OP_SHR,
    OP_AND,
    OP_OR,
    OP_F32_TO_F16,
    OP_F16_TO_F32,
    OP_FADD
  } alu_op_t;

  typedef enum logic [1:0] {
    WIDTH_16,
    WIDTH_32,
    WIDTH_48,
    WIDTH_64
  } access_width_t;

  // One decoded instruction word.
  typedef struct packed {
    alu_op_t              op;
    logic                 cond_ok;
    logic [REG_IDX_W-1:0] dst;
    logic [REG_IDX_W-1:0] src_a;
    logic [REG_IDX_W-1:0] src_b;
    logic [REG_IDX_W-1:0] dst2;
    logic                 use_alt;
    logic                 load_dm;
    logic                 load_pm;
    logic                 dag_step;
    logic [CBUF_IDX_W-1:0] cbuf;
    logic                 branch;
    logic [15:0]          unused_bits;
  } insn_t;

  // Circular buffer register set.
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] length;
    logic [ADDR_W-1:0] modify;
    logic [ADDR_W-1:0] index;
  } cbuf_set_t;

  // Operand pair moved per access, one word for each element.
  typedef struct packed {
    logic [WORD_W-1:0] second;
    logic [WORD_W-1:0] first;
  } data_pair_t;

endpackage

//--- logic/insn_cache.sv
// Selective instruction cache holding fetches that collided with data accesses.
module insn_cache
  import simd_core_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic [ADDR_W-1:0]      lookup_addr_i,
  input  wire logic                   fill_i,
  input  wire logic [INSN_W-1:0]      fill_insn_i,
  output logic                        hit_o,
  output logic [INSN_W-1:0]           insn_o
);

  logic [INSN_W-1:0] line_data [CACHE_DEPTH];
  logic [ADDR_W-1:0] line_tag  [CACHE_DEPTH];
  logic [CACHE_DEPTH-1:0] line_valid;
  logic [CACHE_IDX_W-1:0] slot;

  assign slot = lookup_addr_i[CACHE_IDX_W-1:0];

  // Entries are written only on a collision fill.
  always_ff @(posedge clock_i)
  begin
    if (fill_i)
    begin
      line_data[slot] <= fill_insn_i;
      line_tag[slot]  <= lookup_addr_i;
    end
  end

  // Valid bits clear at reset.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      line_valid <= '0;
    else if (fill_i)
      line_valid[slot] <= 1'b1;
  end

  // Read data and hit come out of registers.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hit_o  <= 1'b0;
      insn_o <= '0;
    end
    else
    begin
      hit_o  <= line_valid[slot] && (line_tag[slot] == lookup_addr_i);
      insn_o <= line_data[slot];
    end
  end

endmodule

//--- logic/simd_dsp_core_datapath.sv
// Two-element SIMD datapath with register files, address generators and cache.
// How it works
// - First element always on; second needs enable.
// - SIMD issues each instruction to both elements.
// - SIMD access moves two values, one per element.
// - ALU, multiplier, shifter parallel, one cycle each.
// - Multifunction runs ALU and multiply together.
// - Float 32, extended 40, fixed 32 formats.
// - Thirty-two registers, sixteen primary, sixteen alternate.
// - One instruction plus four operands per cycle.
// - Cache only fetches colliding with bus data.
// - Sixteen primary, sixteen alternate circular buffers.
// - Hardware pointer wrap, buffers anywhere.
// - 48-bit instruction, conditional multi-op with branch.
// - Two core and one I/O transfer per cycle.
// - Memory sizes 96K, 192K, 64K words limits.
// - Access widths 16, 32, 48, 64 bits.
// - Single-instruction float 32 and 16 conversion.
module simd_dsp_core_datapath
  import simd_core_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic [MODE_W-1:0]      mode_i,
  input  wire logic                   mode_load_i,
  input  wire logic [INSN_W-1:0]      insn_i,
  input  wire logic [ADDR_W-1:0]      fetch_addr_i,
  input  wire logic                   pm_data_busy_i,
  input  wire data_pair_t             dm_rdata_i,
  input  wire data_pair_t             pm_rdata_i,
  input  wire logic                   cbuf_load_i,
  input  wire logic [CBUF_IDX_W-1:0]  cbuf_load_sel_i,
  input  wire logic                   cbuf_load_alt_i,
  input  wire cbuf_set_t              cbuf_load_val_i,
  input  wire access_width_t          width_i,
  input  wire logic [ADDR_W-1:0]      io_addr_i,
  input  wire logic                   io_req_i,
  output logic                        second_active_o,
  output data_pair_t                  result_o,
  output data_pair_t                  result2_o,
  output logic [EXT_W-1:0]            ext_result_o,
  output logic [ADDR_W-1:0]           dm_addr_o,
  output logic [ADDR_W-1:0]           pm_addr_o,
  output logic                        cache_hit_o,
  output logic                        io_grant_o,
  output logic                        addr_range_err_o,
  output logic                        branch_o
);

  insn_t                  insn;
  logic [MODE_W-1:0]      core_mode_control_reg;
  logic                   second_element_enable;
  logic [WORD_W-1:0]      regs [PE_COUNT][REG_COUNT];
  cbuf_set_t              cbufs [2][2*CBUF_SETS];
  logic [WORD_W-1:0]      op_a [PE_COUNT];
  logic [WORD_W-1:0]      op_b [PE_COUNT];
  logic [WORD_W-1:0]      alu_res [PE_COUNT];
  logic [WORD_W-1:0]      alu2_res [PE_COUNT];
  logic                   pe_live [PE_COUNT];
  logic                   cache_hit;
  logic [INSN_W-1:0]      cache_insn;
  logic                   cache_fill;
  logic [ADDR_W-1:0]      next_index [2];
  logic [ADDR_W-1:0]      io_limit;
  logic [REG_IDX_W:0]     bank_off;

  // The decoded fields sit in the top bits; the spare low bits are ignored.
  assign insn = insn_t'(insn_i[INSN_W-1 -: $bits(insn_t)]);
  assign second_element_enable = core_mode_control_reg[SECOND_ELEMENT_ENABLE_BIT];
  assign bank_off = insn.use_alt ? (REG_IDX_W+1)'(BANK_SIZE) : '0;

  // Mode control register; reset leaves SIMD off.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      core_mode_control_reg <= MODE_RESET;
    else if (mode_load_i)
      core_mode_control_reg <= mode_i;
  end

  // Element activity: first always, second only when enabled.
  assign pe_live[0] = 1'b1;
  assign pe_live[1] = second_element_enable;

  // Fetches colliding with a data transfer on the program bus fill the cache.
  assign cache_fill = pm_data_busy_i && !cache_hit;

  insn_cache u_cache (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .lookup_addr_i (fetch_addr_i),
    .fill_i        (cache_fill),
    .fill_insn_i   (insn_i),
    .hit_o         (cache_hit),
    .insn_o        (cache_insn)
  );

  // Per-element compute units, all working on the same decoded instruction.
  genvar pe;
  generate
    for (pe = 0; pe < PE_COUNT; pe++)
    begin : g_pe
      logic [2*WORD_W-1:0] prod;
      logic [WORD_W-1:0]   f16w;
      logic [7:0]          e32;
      logic [7:0]          e16;
      // Operands come from the element's own bank.
      assign op_a[pe] = regs[pe][5'(bank_off + {1'b0, insn.src_a})];
      assign op_b[pe] = regs[pe][5'(bank_off + {1'b0, insn.src_b})];
      assign prod     = op_a[pe] * op_b[pe];
      assign e32      = op_a[pe][WORD_W-2 -: F32_EXP_W];
      assign e16      = {3'h0, op_a[pe][F16_MAN_W +: F16_EXP_W]};

      // Float 32 to 16 and back in one cycle, saturating the exponent.
      always_comb
      begin
        f16w = '0;
        if (insn.op == OP_F32_TO_F16)
        begin
          f16w[15] = op_a[pe][WORD_W-1];
          if (e32 > (F32_BIAS - F16_BIAS + F16_EXP_MAX - 8'h01))
            f16w[14:10] = F16_EXP_MAX[4:0];
          else if (e32 > (F32_BIAS - F16_BIAS))
          begin
            f16w[14:10] = 5'(e32 - (F32_BIAS - F16_BIAS));
            f16w[9:0]   = op_a[pe][F32_MAN_W-1 -: F16_MAN_W];
          end
        end
        else
        begin
          f16w[31]    = op_a[pe][15];
          f16w[30:23] = (e16 == 8'h00) ? 8'h00 : 8'(e16 + (F32_BIAS - F16_BIAS));
          f16w[22:13] = op_a[pe][F16_MAN_W-1:0];
        end
      end

      // ALU, multiplier and shifter side by side, single cycle.
      always_comb
      begin
        alu2_res[pe] = op_a[pe] - op_b[pe];
        unique case (insn.op)
          OP_ADD, OP_ADDSUB, OP_FADD: alu_res[pe] = op_a[pe] + op_b[pe];
          OP_SUB:                     alu_res[pe] = op_a[pe] - op_b[pe];
          OP_MUL:                     alu_res[pe] = prod[WORD_W-1:0];
          OP_MULADD:                  alu_res[pe] = prod[WORD_W-1:0];
          OP_SHL:                     alu_res[pe] = op_a[pe] << op_b[pe][4:0];
          OP_SHR:                     alu_res[pe] = op_a[pe] >> op_b[pe][4:0];
          OP_AND:                     alu_res[pe] = op_a[pe] & op_b[pe];
          OP_OR:                      alu_res[pe] = op_a[pe] | op_b[pe];
          OP_F32_TO_F16, OP_F16_TO_F32: alu_res[pe] = f16w;
          default:                    alu_res[pe] = op_a[pe];
        endcase
        if (insn.op == OP_MULADD)
          alu2_res[pe] = op_a[pe] + op_b[pe];
      end

      // Register file writes, gated by element activity and condition.
      always_ff @(posedge clock_i)
      begin
        if (pe_live[pe] && insn.cond_ok)
        begin
          if (insn.op != OP_NOP)
            regs[pe][5'(bank_off + {1'b0, insn.dst})] <= alu_res[pe];
          if (insn.op == OP_MULADD || insn.op == OP_ADDSUB)
            regs[pe][5'(bank_off + {1'b0, insn.dst2})] <= alu2_res[pe];
          if (insn.load_dm)
            regs[pe][5'(bank_off + {1'b0, insn.src_b})] <=
              (pe == 0) ? dm_rdata_i.first : dm_rdata_i.second;
          if (insn.load_pm)
            regs[pe][5'(bank_off + {1'b0, insn.dst2}) ^ 5'h01] <=
              (pe == 0) ? pm_rdata_i.first : pm_rdata_i.second;
        end
      end
    end
  endgenerate

  // Results: second element results hold while it is disabled.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      result_o  <= '0;
      result2_o <= '0;
    end
    else if (insn.cond_ok)
    begin
      result_o.first  <= alu_res[0];
      result2_o.first <= alu2_res[0];
      if (pe_live[1])
      begin
        result_o.second  <= alu_res[1];
        result2_o.second <= alu2_res[1];
      end
    end
  end

  // Extended-precision view: 32-bit float with eight extra mantissa bits.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ext_result_o <= '0;
    else if (insn.op == OP_FADD)
      ext_result_o <= {alu_res[0], 8'h00};
  end

  // Circular buffer wrap for both generators.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_dag
      cbuf_set_t cur;
      logic [ADDR_W:0] step;
      assign cur  = cbufs[g][{insn.use_alt, insn.cbuf}];
      assign step = {1'b0, cur.index} + {1'b0, cur.modify};
      // Wrap back into [base, base+length) anywhere in memory.
      always_comb
      begin
        if (step >= ({1'b0, cur.base} + {1'b0, cur.length}))
          next_index[g] = ADDR_W'(step - {1'b0, cur.length});
        else
          next_index[g] = step[ADDR_W-1:0];
      end

      always_ff @(posedge clock_i)
      begin
        if (cbuf_load_i)
          cbufs[g][{cbuf_load_alt_i, cbuf_load_sel_i}] <= cbuf_load_val_i;
        else if (insn.dag_step && insn.cond_ok)
          cbufs[g][{insn.use_alt, insn.cbuf}].index <= next_index[g];
      end
    end
  endgenerate

  // Data and program bus addresses each cycle.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dm_addr_o <= '0;
      pm_addr_o <= '0;
    end
    else
    begin
      dm_addr_o <= cbufs[0][{insn.use_alt, insn.cbuf}].index;
      pm_addr_o <= cbufs[1][{insn.use_alt, insn.cbuf}].index;
    end
  end

  // Address limit by width; the I/O port runs beside both core buses.
  always_comb
  begin
    unique case (width_i)
      WIDTH_16: io_limit = '1;  // 16-bit words outnumber the address reach.
      WIDTH_32: io_limit = ADDR_W'(MEM_WORDS_32 - 1);
      WIDTH_48: io_limit = ADDR_W'(MEM_WORDS_48 - 1);
      WIDTH_64: io_limit = ADDR_W'(MEM_WORDS_32 / 2 - 1);
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      io_grant_o       <= 1'b0;
      addr_range_err_o <= 1'b0;
    end
    else
    begin
      io_grant_o       <= io_req_i && (io_addr_i <= io_limit);
      addr_range_err_o <= io_req_i && (io_addr_i > io_limit);
    end
  end

  // Status outputs.
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      second_active_o <= 1'b0;
      cache_hit_o     <= 1'b0;
      branch_o        <= 1'b0;
    end
    else
    begin
      second_active_o <= second_element_enable;
      cache_hit_o     <= cache_hit && (cache_insn != '0);
      branch_o        <= insn.branch && insn.cond_ok;
    end
  end

  // Second element result never changes while disabled.
  property p_second_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    !pe_live[1] |=> $stable(result_o.second);
  endproperty
  a_second_hold: assert property (p_second_hold) else $error("second element changed");

  property p_first_live;
    @(posedge clock_i) disable iff (!rst_n_i)
    insn.cond_ok |=> result_o.first == $past(alu_res[0]);
  endproperty
  a_first_live: assert property (p_first_live) else $error("first element stalled");

  property p_io_grant;
    @(posedge clock_i) disable iff (!rst_n_i)
    (io_req_i && io_addr_i <= io_limit) |=> io_grant_o && !addr_range_err_o;
  endproperty
  a_io_grant: assert property (p_io_grant) else $error("io access refused");

  // An access past the width limit is flagged and never granted.
  property p_io_range;
    @(posedge clock_i) disable iff (!rst_n_i)
    (io_req_i && io_addr_i > io_limit) |=> addr_range_err_o && !io_grant_o;
  endproperty
  a_io_range: assert property (p_io_range) else $error("io range not flagged");

  // The status output follows the mode enable one cycle later.
  property p_second_active;
    @(posedge clock_i) disable iff (!rst_n_i)
    1'b1 |=> second_active_o == $past(second_element_enable);
  endproperty
  a_second_active: assert property (p_second_active) else $error("second status wrong");

  // A taken conditional branch is reported on the next cycle.
  property p_branch;
    @(posedge clock_i) disable iff (!rst_n_i)
    (insn.branch && insn.cond_ok) |=> branch_o;
  endproperty
  a_branch: assert property (p_branch) else $error("branch not reported");

endmodule

//--- sim/mem_io_partner.sv
// Memory stand-in that feeds one read word pair on each of the data and program buses per access to the core.
module mem_io_partner
  import simd_core_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       valid_i,
  input  wire data_pair_t dm_word_i,
  input  wire data_pair_t pm_word_i,
  output data_pair_t      dm_rdata_o,
  output data_pair_t      pm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both buses start from a defined pattern.
  initial
  begin
    dm_rdata_o = '0;
    pm_rdata_o = '0;
  end

  // A valid access shows both words at once, low word for the first element.
  always @(valid_i, dm_word_i, pm_word_i)
    if (valid_i)
    begin
      dm_rdata_o = dm_word_i;
      pm_rdata_o = pm_word_i;
    end

  // Outside an access the buses toggle, so stale data is never mistaken for good.
  always @(posedge clock_i)
  begin
    #6;
    if (!valid_i)
    begin
      dm_rdata_o = ~dm_rdata_o;
      pm_rdata_o = ~pm_rdata_o;
    end
  end
endmodule

//--- sim/test_simd_dsp_core_datapath.sv
// Self-checking bench for the SIMD datapath core against a behavioural model.
module test_simd_dsp_core_datapath
  import simd_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i, rst_n_i, mode_load_i, pm_data_busy_i, cbuf_load_i, cbuf_load_alt_i, io_req_i;
  logic [MODE_W-1:0] mode_i;
  logic [INSN_W-1:0] insn_i;
  logic [ADDR_W-1:0] fetch_addr_i, io_addr_i, dm_addr_o, pm_addr_o;
  logic [CBUF_IDX_W-1:0] cbuf_load_sel_i;
  cbuf_set_t cbuf_load_val_i;
  access_width_t width_i;
  data_pair_t dm_rdata_i, pm_rdata_i, dm_word, pm_word, result_o, result2_o;
  logic [EXT_W-1:0] ext_result_o;
  logic second_active_o, cache_hit_o, io_grant_o, addr_range_err_o, branch_o, mem_valid;
  insn_t cur;
  logic [31:0] rf [2][32];
  logic [31:0] last [2];
  logic [31:0] last2 [2];
  logic [1:0] kn;
  bit en;
  int seed = 32'hd2b7;
  int n_fail, cmp_count, cycles;
  alu_op_t ops [6] = '{OP_ADD, OP_SUB, OP_MUL, OP_AND, OP_OR, OP_FADD};
  int lims [4] = '{196608, 98304, 65536, 49152};

  // The instruction word carries the decoded fields in its top bits.
  assign insn_i = {cur, 2'b00};

  simd_dsp_core_datapath DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
    .mode_load_i(mode_load_i), .insn_i(insn_i), .fetch_addr_i(fetch_addr_i),
    .pm_data_busy_i(pm_data_busy_i), .dm_rdata_i(dm_rdata_i), .pm_rdata_i(pm_rdata_i),
    .cbuf_load_i(cbuf_load_i), .cbuf_load_sel_i(cbuf_load_sel_i),
    .cbuf_load_alt_i(cbuf_load_alt_i), .cbuf_load_val_i(cbuf_load_val_i), .width_i(width_i),
    .io_addr_i(io_addr_i), .io_req_i(io_req_i), .second_active_o(second_active_o),
    .result_o(result_o), .result2_o(result2_o), .ext_result_o(ext_result_o),
    .dm_addr_o(dm_addr_o), .pm_addr_o(pm_addr_o), .cache_hit_o(cache_hit_o),
    .io_grant_o(io_grant_o), .addr_range_err_o(addr_range_err_o), .branch_o(branch_o));

  mem_io_partner partner (.clock_i(clock_i), .valid_i(mem_valid), .dm_word_i(dm_word),
    .pm_word_i(pm_word), .dm_rdata_o(dm_rdata_i), .pm_rdata_o(pm_rdata_i));

  // Free-running core clock of 50 ns.
  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Cuts a hung run short.
  initial
  begin
    cycles = 0;
    forever
    begin
      @(posedge clock_i);
      cycles++;
      if (cycles == 3000)
      begin
        n_fail++;
        stop_test();
      end
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge clock_i);
    #5;
  endtask

  function automatic logic [31:0] alu(alu_op_t o, logic [31:0] x, logic [31:0] y);
    case (o)
      OP_ADD, OP_FADD: return x + y;
      OP_SUB: return x - y;
      OP_MUL: return x * y;
      OP_AND: return x & y;
      default: return x | y;
    endcase
  endfunction

  task automatic set_mode(bit e);
    cur = '0;
    mode_i = {7'h00, e};
    mode_load_i = 1'b1;
    tick();
    mode_load_i = 1'b0;
    // The status output is registered from the mode register, one cycle on.
    tick();
    en = e;
    check("second_active", second_active_o, e);
  endtask

  // Loads register k from the data bus and k xor 1 from the program bus.
  task automatic load(int k, logic alt);
    int s;
    s = alt ? 16 : 0;
    dm_word = {$random(seed), $random(seed)};
    pm_word = {$random(seed), $random(seed)};
    mem_valid = 1'b1;
    cur = '0;
    cur.cond_ok = 1'b1;
    cur.src_b = k[3:0];
    cur.dst2 = k[3:0];
    cur.use_alt = alt;
    cur.load_dm = 1'b1;
    cur.load_pm = 1'b1;
    for (int e = 0; e < 2; e++)
      if (e == 0 || en)
      begin
        rf[e][k + s] = dm_word[32*e +: 32];
        rf[e][(k ^ 1) + s] = pm_word[32*e +: 32];
      end
    kn[0] = 1'b0;
    if (en)
      kn[1] = 1'b0;
    tick();
    mem_valid = 1'b0;
  endtask

  task automatic op(alu_op_t o, logic c, int d, int a, int b, logic alt, logic br);
    int s;
    s = alt ? 16 : 0;
    cur = '0;
    cur.op = o;
    cur.cond_ok = c;
    cur.dst = d[3:0];
    cur.src_a = a[3:0];
    cur.src_b = b[3:0];
    cur.use_alt = alt;
    cur.branch = br;
    for (int e = 0; e < 2; e++)
      if (c && (e == 0 || en))
      begin
        last[e] = alu(o, rf[e][a + s], rf[e][b + s]);
        last2[e] = rf[e][a + s] - rf[e][b + s];
        rf[e][d + s] = last[e];
        kn[e] = 1'b1;
      end
    tick();
    if (kn[0])
      check("result_first", result_o.first, last[0]);
    if (kn[1])
      check("result_second", result_o.second, last[1]);
    if (kn[0])
      check("result2_first", result2_o.first, last2[0]);
    if (kn[1])
      check("result2_second", result2_o.second, last2[1]);
    if (c && o == OP_FADD)
      check("ext_result", ext_result_o, {last[0], 8'h00});
    check("branch", branch_o, br & c);
  endtask

  task automatic look(int addr, logic busy, logic exp);
    fetch_addr_i = addr[16:0];
    pm_data_busy_i = busy;
    tick();
    pm_data_busy_i = 1'b0;
    tick();
    check("cache_hit", cache_hit_o, exp);
  endtask

  // Main sequence.
  initial
  begin
    int a;
    int idx;
    rst_n_i = 1'b0;
    mode_i = '0;
    mode_load_i = 1'b0;
    cur = '0;
    fetch_addr_i = '0;
    pm_data_busy_i = 1'b0;
    cbuf_load_i = 1'b0;
    cbuf_load_sel_i = '0;
    cbuf_load_alt_i = 1'b0;
    cbuf_load_val_i = '0;
    width_i = WIDTH_32;
    io_addr_i = '0;
    io_req_i = 1'b0;
    mem_valid = 1'b0;
    dm_word = '0;
    pm_word = '0;
    last = '{32'h0, 32'h0};
    last2 = '{32'h0, 32'h0};
    kn = 2'b11;
    repeat (20) @(posedge clock_i);
    #5;
    rst_n_i = 1'b1;
    check("reset_flags", {second_active_o, cache_hit_o, io_grant_o, addr_range_err_o, branch_o},
          0);
    check("reset_result", result_o, 0);
    check("reset_result2", result2_o, 0);
    check("reset_ext", ext_result_o, 0);
    check("reset_addr", {dm_addr_o, pm_addr_o}, 0);
    set_mode(1'b1);
    for (int alt = 0; alt < 2; alt++)
      for (int k = 0; k < 16; k += 2)
        load(k, alt[0]);
    // Random operations with the second element switched on and off.
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0)
        set_mode(((i / 8) % 2) == 1);
      if ($random(seed) & 1)
        load($random(seed) & 14, $random(seed) & 1);
      op(ops[i % 6], (i % 7) != 3, $random(seed) & 15, $random(seed) & 15,
         $random(seed) & 15, $random(seed) & 1, (i % 3) == 0);
    end
    look(17'h00A4, 1'b0, 1'b0);
    look(17'h00A4, 1'b1, 1'b0);
    look(17'h00A4, 1'b0, 1'b1);
    look(17'h00C4, 1'b0, 1'b0);
    look(17'h00C4, 1'b0, 1'b0);
    // I/O requests at and just past each width limit, back to back; for 16-bit, twice at the top address.
    for (int w = 0; w < 4; w++)
      for (int j = 0; j < 2; j++)
      begin
        a = (lims[w] - 1 + j > 131071) ? 131071 : lims[w] - 1 + j;
        width_i = access_width_t'(w);
        io_addr_i = a[16:0];
        io_req_i = 1'b1;
        tick();
        check("io_grant_err", {io_grant_o, addr_range_err_o}, (a >= lims[w]) ? 2'b01 : 2'b10);
      end
    io_req_i = 1'b0;
    // A circular buffer at the top of memory must keep its pointer inside.
    cbuf_load_val_i = '{base: 17'h1FFF0, length: 17'h00007, modify: 17'h00003, index: 17'h1FFF0};
    cbuf_load_sel_i = 4'h5;
    cbuf_load_i = 1'b1;
    tick();
    cbuf_load_i = 1'b0;
    cur = '0;
    cur.cond_ok = 1'b1;
    cur.dag_step = 1'b1;
    cur.cbuf = 4'h5;
    idx = 'h1FFF0;
    repeat (12)
    begin
      tick();
      check("dag_dm_addr", dm_addr_o, idx);
      check("dag_pm_addr", pm_addr_o, idx);
      idx = idx + 3;
      if (idx >= 'h1FFF7)
        idx = idx - 7;
    end
    stop_test();
  end
endmodule
